/* acf_defines.svh */
// constants for the acl action field logic
`ifndef ACF_DEFINES_SVH
`define ACF_DEFINES_SVH

// direct register addresses of the indirect access window
`define ACF_REG_CTRL     8'h6E
`define ACF_REG_OFFS     8'h6F
`define ACF_REG_DATA     8'hA0

// table select field in the control register
`define ACF_TBL_MSB      7
`define ACF_TBL_LSB      5
`define ACF_TBL_ACL      3'h2
`define ACF_PORT_MSB     3

// action byte offsets inside one port entry
`define ACF_OFS_PRIO     8'h0A
`define ACF_OFS_FWD      8'h0B

// reset values
`define ACF_RST_BYTE     8'h00
`define ACF_RST_PORT     4'h0

// port count and port map
`define ACF_NUM_PORTS    5
`define ACF_PORT_W       3
`define ACF_FIRST_PORT   4'h1

// priority mode codes
`define ACF_PRIO_QOS     2'h0
`define ACF_PRIO_GREATER 2'h1
`define ACF_PRIO_SMALLER 2'h2
`define ACF_PRIO_REPLACE 2'h3

// map mode codes
`define ACF_MAP_LUT      2'h0
`define ACF_MAP_OR       2'h1
`define ACF_MAP_AND      2'h2
`define ACF_MAP_RULE     2'h3

// counter configuration
`define ACF_MATCH_COUNT  2'h1
`define ACF_EN_COUNT     2'h0
`define ACF_CNT_UNIT_BIT 4
`define ACF_CNT_MODE_BIT 3
`define ACF_CNT_W        11

// time base
`define ACF_CLK_NS       100
`define ACF_US_NS        1000
`define ACF_MS_NS        1000000
`define ACF_PRE_W        16

`endif

/* acf_pkg.sv */
// types for the acl action field logic
package acf_pkg;

    // action byte at offset 0x0A
    typedef struct packed {
        logic [1:0] prio_select_mode;
        logic [2:0] rule_prio;
        logic       remark_enable_bit;
        logic [1:0] remark_prio_hi;
    } acf_prio_byte_t;

    // action byte at offset 0x0B
    typedef struct packed {
        logic       remark_prio_lo;
        logic [1:0] map_combine_mode;
        logic [4:0] rule_port_map;
    } acf_fwd_byte_t;

endpackage

/* acf_action_eval.sv */
// priority selection and forwarding map combination
`timescale 1ns/1ps
`include "acf_defines.svh"

module acf_action_eval (
    input  wire logic [1:0] prio_select_mode_i,
    input  wire logic [2:0] rule_prio_i,
    input  wire logic [2:0] qos_prio_i,
    input  wire logic       tagged_i,
    input  wire logic [1:0] map_combine_mode_i,
    input  wire logic [4:0] rule_map_i,
    input  wire logic [4:0] lut_map_i,
    output logic      [2:0] prio_o,
    output logic      [4:0] map_o
);
    // priority decision against the qos result
    always_comb begin
        prio_o = qos_prio_i;
        if (tagged_i) begin
            case (prio_select_mode_i)
                `ACF_PRIO_GREATER: if (rule_prio_i > qos_prio_i) prio_o = rule_prio_i;
                `ACF_PRIO_SMALLER: if (rule_prio_i < qos_prio_i) prio_o = rule_prio_i;
                `ACF_PRIO_REPLACE: prio_o = rule_prio_i;
                default:         prio_o = qos_prio_i;
            endcase
        end
    end

    // forwarding map combination
    always_comb begin
        case (map_combine_mode_i)
            `ACF_MAP_OR:   map_o = rule_map_i | lut_map_i;
            `ACF_MAP_AND:  map_o = rule_map_i & lut_map_i;
            `ACF_MAP_RULE: map_o = rule_map_i;
            default:      map_o = lut_map_i;
        endcase
    end
endmodule

/* acf_rule_counter.sv */
// per-port 11-bit rule counter, timed down or frame counted up
`timescale 1ns/1ps
`include "acf_defines.svh"

module acf_rule_counter #(
    parameter int CNT_W = `ACF_CNT_W
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             cfg_en_i,
    input  wire logic             unit_ms_i,
    input  wire logic             count_up_i,
    input  wire logic [CNT_W-1:0] limit_i,
    input  wire logic             hit_i,
    input  wire logic             us_tick_i,
    input  wire logic             ms_tick_i,
    output logic                  irq_o,
    output logic      [CNT_W-1:0] count_o
);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic             irq;
    } acf_cnt_state_t;

    acf_cnt_state_t q, d;
    logic           tick;

    // elaboration check on the counter width
    if (CNT_W < 2) begin : g_bad_width
        $error("counter width too small");
    end

    // count unit select
    assign tick = unit_ms_i ? ms_tick_i : us_tick_i;

    // counter next state
    always_comb begin
        d     = q;
        d.irq = 1'b0;
        if (!cfg_en_i) begin
            d.cnt = '0;
            d.run = 1'b0;
        end else if (count_up_i) begin
            d.run = 1'b0;
            if (hit_i) begin
                if (q.cnt + ONE == limit_i) begin
                    d.cnt = '0;
                    d.irq = 1'b1;
                end else begin
                    d.cnt = q.cnt + ONE;
                end
            end
        end else if (hit_i) begin
            d.cnt = limit_i;
            d.run = 1'b1;
        end else if (q.run && tick) begin
            if (q.cnt <= ONE) begin
                d.cnt = '0;
                d.run = 1'b0;
                d.irq = 1'b1;
            end else begin
                d.cnt = q.cnt - ONE;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign irq_o   = q.irq;
    assign count_o = q.cnt;
endmodule

/* acf_action_top.sv */
// acl action field logic: indirect action bytes, priority, map, rule counters
// Behaviour
// - indirect acl access needs table select 010 and port 1..5 in bits 3:0
// - offset register picks action byte 0x0A or 0x0B, data through 0xA0
// - priority mode 00 keeps the qos/classification priority
// - mode 01 uses rule priority only when greater than qos result
// - mode 10 uses rule priority only when smaller than qos result
// - mode 11 always substitutes the rule priority on tagged frames
// - rule priority is the 3-bit field below the priority mode
// - remark enable set overwrites vlan priority with remark priority
// - remark priority bits 2:1 in byte 0x0A bits 1:0, bit 0 in 0x0B bit 7
// - map mode 00 forwards with lookup map only
// - map mode 01 forwards to rule map or lookup map
// - map mode 10 forwards to rule map and lookup map
// - map mode 11 forwards with rule map alone
// - rule port map bit 0 is port 1 up to bit 4 port 5
// - match mode 01 with enable 00 turns map bits into counter config
// - counter config map bit 4 picks microsecond or millisecond unit
// - map bit 3 clear counts down from the limit, interrupt on expiry
// - map bit 3 set counts matched frames up, interrupt at the limit
`timescale 1ns/1ps
`include "acf_defines.svh"

module acf_action_top #(
    parameter int US_CYCLES = `ACF_US_NS / `ACF_CLK_NS,
    parameter int MS_CYCLES = `ACF_MS_NS / `ACF_CLK_NS
) (
    input  wire logic                            ref_clk_i,
    input  wire logic                            rst_i,
    // byte register port
    input  wire logic [7:0]                      reg_addr_i,
    input  wire logic [7:0]                      reg_wdata_i,
    input  wire logic                            reg_wr_i,
    input  wire logic                            reg_rd_i,
    output logic      [7:0]                      reg_rdata_o,
    // frame decision request
    input  wire logic                            frm_valid_i,
    input  wire logic [`ACF_PORT_W-1:0]          frm_port_i,
    input  wire logic                            frm_match_i,
    input  wire logic                            frm_tagged_i,
    input  wire logic [2:0]                      qos_prio_i,
    input  wire logic [2:0]                      vlan_prio_i,
    input  wire logic [`ACF_NUM_PORTS-1:0]       lut_map_i,
    // matching field mode bits, two per port
    input  wire logic [2*`ACF_NUM_PORTS-1:0]     match_mode_sel_i,
    input  wire logic [2*`ACF_NUM_PORTS-1:0]     match_enable_sel_i,
    // frame decision result
    output logic                                 res_valid_o,
    output logic      [2:0]                      res_prio_o,
    output logic      [2:0]                      res_vlan_prio_o,
    output logic                                 res_remark_o,
    output logic      [`ACF_NUM_PORTS-1:0]       res_map_o,
    // counter events, one per port
    output logic      [`ACF_NUM_PORTS-1:0]       rule_irq_o
);
    import acf_pkg::*;

    localparam int NP = `ACF_NUM_PORTS;

    typedef struct packed {
        logic [7:0]                 ctrl;
        logic [7:0]                 offs;
        acf_prio_byte_t [NP-1:0]    pa;
        acf_fwd_byte_t  [NP-1:0]    pb;
        logic [7:0]                 rdata;
        logic [`ACF_PRE_W-1:0]      us_cnt;
        logic [`ACF_PRE_W-1:0]      ms_cnt;
        logic                       us_tick;
        logic                       ms_tick;
        logic                       res_valid;
        logic [2:0]                 res_prio;
        logic [2:0]                 res_vlan_prio;
        logic                       res_remark;
        logic [NP-1:0]              res_map;
    } acf_top_state_t;

    acf_top_state_t q, d;

    // elaboration checks on the prescaler lengths
    if (US_CYCLES < 1 || US_CYCLES >= (1 << `ACF_PRE_W)) begin : g_bad_us
        $error("US_CYCLES out of range");
    end
    if (MS_CYCLES < 1 || MS_CYCLES >= (1 << `ACF_PRE_W)) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end

    localparam logic [`ACF_PRE_W-1:0] US_LAST = `ACF_PRE_W'(US_CYCLES - 1);
    localparam logic [`ACF_PRE_W-1:0] MS_LAST = `ACF_PRE_W'(MS_CYCLES - 1);
    localparam logic [`ACF_PRE_W-1:0] PRE_ONE = `ACF_PRE_W'(1);

    // port number 1..5 is a valid entry selector
    function automatic logic port_ok(input logic [3:0] n);
        port_ok = (n >= `ACF_FIRST_PORT) && (n <= 4'(NP));
    endfunction

    // port number to entry index, bit 0 of the map is port 1
    function automatic logic [`ACF_PORT_W-1:0] port_idx(input logic [3:0] n);
        logic [3:0] t;
        t        = n - `ACF_FIRST_PORT;
        port_idx = t[`ACF_PORT_W-1:0];
    endfunction

    // match mode and enable that turn the map into counter config
    function automatic logic cnt_cfg(input logic [1:0] mode, input logic [1:0] en);
        cnt_cfg = (mode == `ACF_MATCH_COUNT) && (en == `ACF_EN_COUNT);
    endfunction

    // indirect window decode
    logic                  win_ok;
    logic [`ACF_PORT_W-1:0] win_idx;
    assign win_ok  = (q.ctrl[`ACF_TBL_MSB:`ACF_TBL_LSB] == `ACF_TBL_ACL)
                     && port_ok(q.ctrl[`ACF_PORT_MSB:0]);
    assign win_idx = port_idx(q.ctrl[`ACF_PORT_MSB:0]);

    // frame side decode
    logic                   frm_ok;
    logic [`ACF_PORT_W-1:0] frm_idx;
    logic [NP-1:0]          cfg_en;
    acf_prio_byte_t         fa;
    acf_fwd_byte_t          fb;
    logic [2:0]             eval_prio;
    logic [NP-1:0]          eval_map;
    logic [2:0]             remark_val;

    assign frm_ok  = port_ok({1'b0, frm_port_i});
    assign frm_idx = port_idx({1'b0, frm_port_i});
    assign fa      = q.pa[frm_idx];
    assign fb      = q.pb[frm_idx];

    // remark priority assembled from both action bytes
    assign remark_val = {fa.remark_prio_hi, fb.remark_prio_lo};

    // priority and map evaluation for the ingress port entry
    acf_action_eval u_eval (
        .prio_select_mode_i (fa.prio_select_mode),
        .rule_prio_i        (fa.rule_prio),
        .qos_prio_i         (qos_prio_i),
        .tagged_i           (frm_tagged_i),
        .map_combine_mode_i (fb.map_combine_mode),
        .rule_map_i         (fb.rule_port_map),
        .lut_map_i          (lut_map_i),
        .prio_o             (eval_prio),
        .map_o              (eval_map)
    );

    // per-port rule counters
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_cnt
            logic [`ACF_CNT_W-1:0] limit;
            logic                  hit;

            assign cfg_en[gp] = cnt_cfg(match_mode_sel_i[2*gp +: 2],
                                        match_enable_sel_i[2*gp +: 2]);
            // limit taken from the remaining action fields
            assign limit = {q.pa[gp].prio_select_mode, q.pa[gp].rule_prio,
                            q.pa[gp].remark_enable_bit, q.pa[gp].remark_prio_hi,
                            q.pb[gp].remark_prio_lo,
                            q.pb[gp].map_combine_mode};
            assign hit = frm_valid_i && frm_match_i && frm_ok
                         && (frm_idx == `ACF_PORT_W'(gp));

            acf_rule_counter #(
                .CNT_W (`ACF_CNT_W)
            ) u_cnt (
                .ref_clk_i  (ref_clk_i),
                .rst_i      (rst_i),
                .cfg_en_i   (cfg_en[gp]),
                .unit_ms_i  (q.pb[gp].rule_port_map[`ACF_CNT_UNIT_BIT]),
                .count_up_i (q.pb[gp].rule_port_map[`ACF_CNT_MODE_BIT]),
                .limit_i    (limit),
                .hit_i      (hit),
                .us_tick_i  (q.us_tick),
                .ms_tick_i  (q.ms_tick),
                .irq_o      (rule_irq_o[gp]),
                .count_o    ()
            );
        end
    endgenerate

    // next state: time base, register window, frame result
    always_comb begin
        d           = q;
        d.us_tick   = 1'b0;
        d.ms_tick   = 1'b0;
        d.res_valid = 1'b0;

        // microsecond and millisecond enables
        if (q.us_cnt == US_LAST) begin
            d.us_cnt  = '0;
            d.us_tick = 1'b1;
        end else begin
            d.us_cnt = q.us_cnt + PRE_ONE;
        end
        if (q.ms_cnt == MS_LAST) begin
            d.ms_cnt  = '0;
            d.ms_tick = 1'b1;
        end else begin
            d.ms_cnt = q.ms_cnt + PRE_ONE;
        end

        // register writes
        if (reg_wr_i) begin
            if (reg_addr_i == `ACF_REG_CTRL) begin
                d.ctrl = reg_wdata_i;
            end else if (reg_addr_i == `ACF_REG_OFFS) begin
                d.offs = reg_wdata_i;
            end else if (reg_addr_i == `ACF_REG_DATA && win_ok) begin
                if (q.offs == `ACF_OFS_PRIO) begin
                    d.pa[win_idx] = acf_prio_byte_t'(reg_wdata_i);
                end else if (q.offs == `ACF_OFS_FWD) begin
                    d.pb[win_idx] = acf_fwd_byte_t'(reg_wdata_i);
                end
            end
        end

        // register reads, unmapped or unselected read as zero
        if (reg_rd_i) begin
            if (reg_addr_i == `ACF_REG_CTRL) begin
                d.rdata = q.ctrl;
            end else if (reg_addr_i == `ACF_REG_OFFS) begin
                d.rdata = q.offs;
            end else if (reg_addr_i == `ACF_REG_DATA && win_ok
                         && q.offs == `ACF_OFS_PRIO) begin
                d.rdata = q.pa[win_idx];
            end else if (reg_addr_i == `ACF_REG_DATA && win_ok
                         && q.offs == `ACF_OFS_FWD) begin
                d.rdata = q.pb[win_idx];
            end else begin
                d.rdata = `ACF_RST_BYTE;
            end
        end

        // frame decision, actions only for a matched rule not in counter use
        if (frm_valid_i) begin
            d.res_valid     = 1'b1;
            d.res_prio      = qos_prio_i;
            d.res_map       = lut_map_i;
            d.res_remark    = 1'b0;
            d.res_vlan_prio = vlan_prio_i;
            if (frm_match_i && frm_ok && !cfg_en[frm_idx]) begin
                d.res_prio = eval_prio;
                d.res_map  = eval_map;
                if (fa.remark_enable_bit) begin
                    d.res_remark    = 1'b1;
                    d.res_vlan_prio = remark_val;
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q      <= '0;
            q.ctrl <= `ACF_RST_BYTE;
            q.offs <= `ACF_RST_BYTE;
        end else begin
            q <= d;
        end
    end

    // outputs from flops
    assign reg_rdata_o     = q.rdata;
    assign res_valid_o     = q.res_valid;
    assign res_prio_o      = q.res_prio;
    assign res_vlan_prio_o = q.res_vlan_prio;
    assign res_remark_o    = q.res_remark;
    assign res_map_o       = q.res_map;
endmodule

/* acf_action_props.sv */
// assertion checker bound to the acl action top
`timescale 1ns/1ps
module acf_action_props (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       frm_valid_i,
    input wire logic [2:0] frm_port_i,
    input wire logic       frm_match_i,
    input wire logic       frm_tagged_i,
    input wire logic [2:0] qos_prio_i,
    input wire logic [2:0] vlan_prio_i,
    input wire logic [4:0] lut_map_i,
    input wire logic [9:0] match_mode_sel_i,
    input wire logic [9:0] match_enable_sel_i,
    input wire logic       res_valid_o,
    input wire logic [2:0] res_prio_o,
    input wire logic [2:0] res_vlan_prio_o,
    input wire logic       res_remark_o,
    input wire logic [4:0] res_map_o,
    input wire logic [4:0] rule_irq_o
);
    // single clock domain, reset disables all checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // result pulse one cycle after each request
    property p_res_one;
        res_valid_o == $past(frm_valid_i);
    endproperty
    a_res_one: assert property (p_res_one) else $error("result pulse misplaced");
    // no match keeps lookup map and no remark
    property p_miss_map;
        frm_valid_i && !frm_match_i |=> res_map_o == $past(lut_map_i) && !res_remark_o;
    endproperty
    a_miss_map: assert property (p_miss_map) else $error("unmatched map changed");
    // no match keeps qos priority
    property p_miss_prio;
        frm_valid_i && !frm_match_i |=> res_prio_o == $past(qos_prio_i);
    endproperty
    a_miss_prio: assert property (p_miss_prio) else $error("unmatched prio changed");
    // untagged frames keep qos priority
    property p_untag_prio;
        frm_valid_i && !frm_tagged_i |=> res_prio_o == $past(qos_prio_i);
    endproperty
    a_untag_prio: assert property (p_untag_prio) else $error("untagged prio changed");
    // vlan priority passes through without remark
    property p_keep_vlan;
        res_valid_o && !res_remark_o |-> res_vlan_prio_o == $past(vlan_prio_i);
    endproperty
    a_keep_vlan: assert property (p_keep_vlan) else $error("vlan prio changed");
    // ports outside 1..5 have no entry
    property p_bad_port;
        frm_valid_i && (frm_port_i == 3'h0 || frm_port_i > 3'h5) |=> res_map_o == $past(lut_map_i);
    endproperty
    a_bad_port: assert property (p_bad_port) else $error("bad port changed map");
    // map and priority results hold between result pulses
    property p_hold;
        !res_valid_o |-> $stable(res_map_o) && $stable(res_prio_o);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without pulse");
    // port 1 interrupt only from counter configuration
    property p_irq_cfg;
        rule_irq_o[0] |-> $past(match_mode_sel_i[1:0]) == 2'h1
            && $past(match_enable_sel_i[1:0]) == 2'h0;
    endproperty
    a_irq_cfg: assert property (p_irq_cfg) else $error("irq outside counter config");
    // unmapped reads return zero
    property p_rd_unmapped;
        reg_rd_i && reg_addr_i != 8'h6E && reg_addr_i != 8'h6F && reg_addr_i != 8'hA0
            |=> reg_rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    // read data holds until the next read
    property p_rd_hold;
        !$past(reg_rd_i) |-> $stable(reg_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind acf_action_top acf_action_props u_acf_action_props (
    .ref_clk_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .frm_valid_i, .frm_port_i,
    .frm_match_i, .frm_tagged_i, .qos_prio_i, .vlan_prio_i, .lut_map_i, .match_mode_sel_i,
    .match_enable_sel_i, .res_valid_o, .res_prio_o, .res_vlan_prio_o, .res_remark_o,
    .res_map_o, .rule_irq_o
);

/* acl_action_field_logic_tb_top.sv */
// self-checking bench for the acl action field logic
`timescale 1ns/1ps
module acl_action_field_logic_tb_top;
    logic        ref_clk_i;
    logic        rst_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        frm_valid_i = 1'b0;
    logic [2:0]  frm_port_i = 3'h0;
    logic        frm_match_i = 1'b0;
    logic        frm_tagged_i = 1'b0;
    logic [2:0]  qos_prio_i = 3'h0;
    logic [2:0]  vlan_prio_i = 3'h0;
    logic [4:0]  lut_map_i = 5'h00;
    logic [9:0]  match_mode_sel_i = 10'h000;
    logic [9:0]  match_enable_sel_i = 10'h000;
    logic        res_valid_o;
    logic [2:0]  res_prio_o;
    logic [2:0]  res_vlan_prio_o;
    logic        res_remark_o;
    logic [4:0]  res_map_o;
    logic [4:0]  rule_irq_o;
    // reference model state
    logic [7:0]  m_a [1:5];
    logic [7:0]  m_b [1:5];
    logic [7:0]  m_ctrl = 8'h00;
    logic [7:0]  m_offs = 8'h00;
    logic [31:0] seed = 32'h2A18EBD8;
    int          cnt = 0;
    int          bad_count = 0;
    int          num_checks = 0;

    acf_action_top #(.US_CYCLES(2), .MS_CYCLES(5)) u_acf_action_top (
        .ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .frm_valid_i, .frm_port_i, .frm_match_i, .frm_tagged_i, .qos_prio_i, .vlan_prio_i,
        .lut_map_i, .match_mode_sel_i, .match_enable_sel_i, .res_valid_o, .res_prio_o,
        .res_vlan_prio_o, .res_remark_o, .res_map_o, .rule_irq_o
    );

    // clock and watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #2000000;
        bad_count++;
        print_verdict();
    end

    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic win();
        return m_ctrl[7:5] == 3'h2 && m_ctrl[3:0] >= 4'h1 && m_ctrl[3:0] <= 4'h5
            && (m_offs == 8'h0A || m_offs == 8'h0B);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk_i);
        #5;
    endtask
    // register write with model update
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick();
        reg_wr_i = 1'b0;
        if (a == 8'h6E) m_ctrl = d;
        else if (a == 8'h6F) m_offs = d;
        else if (a == 8'hA0 && win() && m_offs == 8'h0A) m_a[m_ctrl[3:0]] = d;
        else if (a == 8'hA0 && win()) m_b[m_ctrl[3:0]] = d;
        tick();
    endtask
    // register read compared with model
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick();
        reg_rd_i = 1'b0;
        e = 8'h00;
        if (a == 8'h6E) e = m_ctrl;
        else if (a == 8'h6F) e = m_offs;
        else if (a == 8'hA0 && win()) e = m_offs == 8'h0A ? m_a[m_ctrl[3:0]] : m_b[m_ctrl[3:0]];
        chk(reg_rdata_o, e, "read");
        tick();
    endtask
    task automatic acl(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
        wr({4'h4, p}, 8'h00);
        wr(8'h6E, {4'h4, p});
        wr(8'h6F, o);
        wr(8'hA0, d);
    endtask
    task automatic acl_rd(input logic [3:0] p, input logic [7:0] o);
        wr(8'h6E, {4'h4, p});
        wr(8'h6F, o);
        rd(8'hA0);
    endtask
    // one frame request, held back to back, checked a cycle later
    task automatic frm(input logic [2:0] p, input logic [31:0] r);
        logic [7:0] a;
        logic [7:0] b;
        logic [2:0] ep;
        logic [2:0] ev;
        logic [4:0] em;
        logic [4:0] ei;
        logic       er;
        logic       cf;
        logic       ok;
        ok = p >= 3'h1 && p <= 3'h5;
        a = ok ? m_a[p] : 8'h00;
        b = ok ? m_b[p] : 8'h00;
        cf = ok && match_mode_sel_i[2*(p-1) +: 2] == 2'h1;
        cf = cf && match_enable_sel_i[2*(p-1) +: 2] == 2'h0;
        frm_port_i = p;
        frm_match_i = r[3] | r[4];
        frm_tagged_i = r[5] | r[6];
        qos_prio_i = r[9:7];
        vlan_prio_i = r[12:10];
        lut_map_i = r[17:13];
        frm_valid_i = 1'b1;
        ep = qos_prio_i;
        ev = vlan_prio_i;
        em = lut_map_i;
        er = 1'b0;
        ei = 5'h00;
        if (ok && frm_match_i && !cf) begin
            if (frm_tagged_i && (a[7:6] == 2'h3 || (a[7:6] == 2'h1 && a[5:3] > ep)
                || (a[7:6] == 2'h2 && a[5:3] < ep))) ep = a[5:3];
            er = a[2];
            if (er) ev = {a[1:0], b[7]};
            if (b[6:5] == 2'h1) em = em | b[4:0];
            if (b[6:5] == 2'h2) em = em & b[4:0];
            if (b[6:5] == 2'h3) em = b[4:0];
        end
        if (ok && frm_match_i && cf && b[3]) begin
            cnt++;
            if (cnt == {a, b[7:5]}) begin
                ei[p-1] = 1'b1;
                cnt = 0;
            end
        end
        tick();
        chk({7'h0, res_valid_o}, 8'h01, "valid");
        chk({5'h0, res_prio_o}, {5'h0, ep}, "prio");
        chk({3'h0, res_map_o}, {3'h0, em}, "map");
        chk({3'h0, rule_irq_o}, {3'h0, ei}, "irq");
        chk({4'h0, res_remark_o, res_vlan_prio_o}, {4'h0, er, ev}, "rmk");
    endtask
    // countdown on port 2, interrupt delay bounded by the tick unit
    task automatic down(input logic [7:0] b, input int lo, input int hi);
        int n;
        acl(4'h2, 8'h0A, 8'h00);
        acl(4'h2, 8'h0B, b);
        match_mode_sel_i = 10'h004;
        frm(3'h2, 32'h00000078);
        frm_valid_i = 1'b0;
        n = 1;
        while (rule_irq_o[1] !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        num_checks++;
        if (n < lo || n > hi) begin
            bad_count++;
            $display("unexpected at %0t: countdown irq after %0d cycles", $time, n);
        end
        match_mode_sel_i = 10'h000;
        tick();
    endtask

    // main sequence
    initial begin
        logic [31:0] r;
        logic [2:0]  p;
        for (int i = 1; i <= 5; i++) begin
            m_a[i] = 8'h00;
            m_b[i] = 8'h00;
        end
        repeat (5) @(posedge ref_clk_i);
        #5;
        rst_i = 1'b0;
        for (int i = 1; i <= 5; i++) begin
            acl_rd(i[3:0], 8'h0A);
            acl_rd(i[3:0], 8'h0B);
        end
        wr(8'h6E, 8'h62);
        wr(8'h6F, 8'h0A);
        wr(8'hA0, 8'hFF);
        acl_rd(4'h2, 8'h0A);
        acl(4'h0, 8'h0A, 8'hFF);
        rd(8'hA0);
        acl(4'h6, 8'h0B, 8'hFF);
        rd(8'hA0);
        acl(4'h3, 8'h0C, 8'hFF);
        rd(8'hA0);
        rd(8'h6E);
        rd(8'h55);
        for (int i = 0; i < 32; i++) begin
            r = nxt();
            p = 3'(1 + r[15:0] % 5);
            acl({1'b0, p}, 8'h0A, {i[1:0], r[21:16]});
            acl({1'b0, p}, 8'h0B, {r[22], i[3:2], r[27:23]});
            acl_rd({1'b0, p}, 8'h0A);
            acl_rd({1'b0, p}, 8'h0B);
            for (int k = 0; k < 6; k++) begin
                r = nxt();
                frm(r[31] ? p : r[2:0], r);
            end
            frm_valid_i = 1'b0;
        end
        acl(4'h1, 8'h0A, 8'h00);
        acl(4'h1, 8'h0B, 8'h68);
        match_mode_sel_i = 10'h001;
        cnt = 0;
        repeat (7) frm(3'h1, nxt() | 32'h8);
        frm_valid_i = 1'b0;
        match_mode_sel_i = 10'h000;
        down(8'h40, 2, 7);
        down(8'h70, 10, 17);
        print_verdict();
    end
endmodule
